/* File: rtl/supply_supervisor_wakeup_ctrl.v */
// supply supervisor/monitor state, settling delays and wake-up masking
// control words and sleep-entry/clear events come from same-clock logic;
// the wake interrupt arrives asynchronously and is synchronised here
`include "supply_supervisor_regs.vh"

// Functional notes
// - slow low side masks processor 150 us on wake from sleep three/four.
// - masking is 2 us when low side disabled/full perf and clock fast.
// - subsystem clock from oscillator is never masked; fast up to 6 us. (code: only after mode code 3, not code 2)
// - full-performance low side settles in 2 us; core raise then resets.
// - normal low side settles in 150 us; software selects it first.
// - each low unit: fast wake if off/full, slow 150 us if normal.
// - supervisor sleep state by manual/auto control and keep/full bits.
// - monitor sleep state: manual keeps, auto drops one level.
// - each control write starts settling; per-side delay flag until done.
// - interrupt within 1 us of sleep entry may be lost when affected.
// - fault needs fast/off low side and high side normal-to-off.
module supply_supervisor_wakeup_ctrl #(
  parameter        CW             = 18,
  parameter [31:0] SLOW_CYC       = `SLOW_SETTLE_CYC,
  parameter [31:0] FAST_CYC       = `FAST_SETTLE_CYC,
  parameter [31:0] SUBCLK_CYC     = `SUBCLK_FAST_CYC,
  parameter [31:0] LOSS_CYC       = 32'd250
) (
  input  wire                  clk_in,
  input  wire                  resetn_in,
  input  wire [`CTL_WIDTH-1:0] low_side_supervisor_ctrl_in,
  input  wire                  low_ctrl_write_in,
  input  wire [`CTL_WIDTH-1:0] high_side_supervisor_ctrl_in,
  input  wire                  high_ctrl_write_in,
  input  wire                  core_level_raise_in,
  input  wire                  main_clock_fast_in,
  input  wire                  subsystem_clock_on_osc_in,
  input  wire [1:0]            sleep_mode_req_in,
  input  wire                  sleep_enter_in,
  input  wire                  wake_irq_in,
  input  wire                  soft_power_up_clear_in,
  output reg                   low_side_delay_flag_out,
  output reg                   high_side_delay_flag_out,
  output reg                   cpu_hold_out,
  output reg                   in_deep_sleep_out,
  output reg                   subsystem_clock_fast_out,
  output reg                   core_level_reset_out,
  output reg                   config_affected_out,
  output reg                   wake_lost_out,
  output reg [1:0]             low_sup_state_out,
  output reg [1:0]             low_mon_state_out,
  output reg [1:0]             high_sup_state_out,
  output reg [1:0]             high_mon_state_out
);
  localparam [1:0] S_ACTIVE = 2'h0;
  localparam [1:0] S_SLEEP  = 2'h1;
  localparam [1:0] S_MASK   = 2'h2;
  localparam [1:0] S_STUCK  = 2'h3;

  // supervisor state in sleep (active when awake)
  function [1:0] sup_state;
    input [`CTL_WIDTH-1:0] c;
    input                  asleep;
    begin
      if (!c[`CTL_SUP_EN])
        sup_state = `ST_OFF;
      else if (!asleep)
        sup_state = c[`CTL_SUP_FP] ? `ST_FULL : `ST_NORMAL;
      else if (c[`CTL_AUTO])
        sup_state = (c[`CTL_SUP_KEEP] && c[`CTL_SUP_FP]) ?
                    `ST_NORMAL : `ST_OFF;
      else if (!c[`CTL_SUP_KEEP])
        sup_state = `ST_OFF;
      else
        sup_state = c[`CTL_SUP_FP] ? `ST_FULL : `ST_NORMAL;
    end
  endfunction

  // monitor state in sleep (active when awake)
  function [1:0] mon_state;
    input [`CTL_WIDTH-1:0] c;
    input                  asleep;
    begin
      if (!c[`CTL_MON_EN])
        mon_state = `ST_OFF;
      else if (asleep && c[`CTL_AUTO])
        mon_state = c[`CTL_MON_FP] ? `ST_NORMAL : `ST_OFF;
      else
        mon_state = c[`CTL_MON_FP] ? `ST_FULL : `ST_NORMAL;
    end
  endfunction

  reg [`CTL_WIDTH-1:0] low_ctl;
  reg [`CTL_WIDTH-1:0] high_ctl;
  reg [1:0]            state;
  reg [1:0]            sleep_mode;
  reg                  irq_meta;
  reg                  irq_sync;
  reg [CW-1:0]         mask_left;
  reg [CW-1:0]         sub_left;
  reg [CW-1:0]         since_entry;
  reg                  skipped_settle;
  reg                  raise_pending;

  wire low_busy;
  wire high_busy;

  // per-unit fast wake: off or full performance
  wire low_sup_fast = !low_ctl[`CTL_SUP_EN] || low_ctl[`CTL_SUP_FP];
  wire low_mon_fast = !low_ctl[`CTL_MON_EN] || low_ctl[`CTL_MON_FP];
  wire any_low_fast = low_sup_fast || low_mon_fast;
  // short_mask needs both low units fast and clock fast; both fast with a slow clock also masks short
  wire short_mask   = low_sup_fast && low_mon_fast && main_clock_fast_in;
  wire mode_34      = sleep_mode != 2'h2;
  // high side goes normal to off on sleep entry
  wire high_sup_hit = high_ctl[`CTL_SUP_EN] && !high_ctl[`CTL_SUP_FP] &&
                      (!high_ctl[`CTL_SUP_KEEP] || high_ctl[`CTL_AUTO]);
  wire high_mon_hit = high_ctl[`CTL_MON_EN] && !high_ctl[`CTL_MON_FP] &&
                      high_ctl[`CTL_AUTO];
  wire affected     = any_low_fast && (high_sup_hit || high_mon_hit);
  wire settle_load_low  = low_ctrl_write_in;
  wire settle_load_high = high_ctrl_write_in;
  // settle time follows the newly written low-side performance
  wire [CW-1:0] low_settle = low_side_supervisor_ctrl_in[`CTL_SUP_FP] ?
                             FAST_CYC[CW-1:0] : SLOW_CYC[CW-1:0];
  wire [CW-1:0] high_settle = high_side_supervisor_ctrl_in[`CTL_SUP_FP] ?
                              FAST_CYC[CW-1:0] : SLOW_CYC[CW-1:0];
  wire entry_window = since_entry < LOSS_CYC[CW-1:0];
  wire swallow      = irq_sync && entry_window && (affected || skipped_settle);

  // each control write restarts its side's settling delay
  settle_timer #(.W(CW)) u_low_settle (
    .clk_in    (clk_in),
    .resetn_in (resetn_in),
    .load_in   (settle_load_low),
    .count_in  (low_settle),
    .busy_out  (low_busy)
  );

  settle_timer #(.W(CW)) u_high_settle (
    .clk_in    (clk_in),
    .resetn_in (resetn_in),
    .load_in   (settle_load_high),
    .count_in  (high_settle),
    .busy_out  (high_busy)
  );

  // two-flop synchroniser for the asynchronous wake interrupt
  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      irq_meta <= 1'b0;
      irq_sync <= 1'b0;
    end else begin
      irq_meta <= wake_irq_in;
      irq_sync <= irq_meta;
    end
  end

  // control registers captured on write strobes
  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      low_ctl  <= `CTL_RESET;
      high_ctl <= `CTL_RESET;
    end else begin
      if (low_ctrl_write_in)
        low_ctl <= low_side_supervisor_ctrl_in;
      if (high_ctrl_write_in)
        high_ctl <= high_side_supervisor_ctrl_in;
    end
  end

  // sleep / wake sequencer with processor masking
  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state          <= S_ACTIVE;
      sleep_mode     <= 2'h0;
      mask_left      <= {CW{1'b0}};
      since_entry    <= {CW{1'b0}};
      skipped_settle <= 1'b0;
      wake_lost_out  <= 1'b0;
    end else begin
      case (state)
        S_ACTIVE: begin
          if (sleep_enter_in && sleep_mode_req_in >= 2'h2) begin
            state          <= S_SLEEP;
            sleep_mode     <= sleep_mode_req_in;
            since_entry    <= {CW{1'b0}};
            skipped_settle <= low_busy || high_busy;
          end
        end
        S_SLEEP: begin
          if (entry_window)
            since_entry <= since_entry + {{(CW-1){1'b0}}, 1'b1};
          // early interrupt in affected setup is swallowed
          if (swallow) begin
            state         <= S_STUCK;
            wake_lost_out <= 1'b1;
          end else if (irq_sync) begin
            // masking begins on the wake event
            state <= S_MASK;
            if (short_mask)
              mask_left <= FAST_CYC[CW-1:0];
            else if (low_sup_fast && low_mon_fast)
              mask_left <= FAST_CYC[CW-1:0];
            else
              mask_left <= SLOW_CYC[CW-1:0];
          end
        end
        S_MASK: begin
          if (mask_left > {{(CW-1){1'b0}}, 1'b1})
            mask_left <= mask_left - {{(CW-1){1'b0}}, 1'b1};
          else begin
            mask_left <= {CW{1'b0}};
            state     <= S_ACTIVE;
          end
        end
        S_STUCK: begin
          // only a soft power-up clear recovers
          if (soft_power_up_clear_in) begin
            state         <= S_ACTIVE;
            wake_lost_out <= 1'b0;
          end
        end
        default: state <= S_ACTIVE;
      endcase
    end
  end

  // subsystem clock runs unmasked and fast after sleep with mode code 3 only, not code 2
  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      sub_left                 <= {CW{1'b0}};
      subsystem_clock_fast_out <= 1'b0;
    end else if (state == S_SLEEP && irq_sync && !swallow && mode_34 &&
                 subsystem_clock_on_osc_in) begin
      sub_left                 <= SUBCLK_CYC[CW-1:0];
      subsystem_clock_fast_out <= 1'b1;
    end else if (sub_left > {{(CW-1){1'b0}}, 1'b1}) begin
      sub_left <= sub_left - {{(CW-1){1'b0}}, 1'b1};
    end else begin
      sub_left                 <= {CW{1'b0}};
      subsystem_clock_fast_out <= 1'b0;
    end
  end

  // core raise with low supervisor enabled in full performance leads to reset
  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      raise_pending        <= 1'b0;
      core_level_reset_out <= 1'b0;
    end else begin
      if (core_level_raise_in)
        raise_pending <= low_ctl[`CTL_SUP_EN] && low_ctl[`CTL_SUP_FP];
      else
        raise_pending <= 1'b0;
      core_level_reset_out <= raise_pending;
    end
  end

  // registered status outputs; state bit 0 marks sleep or stuck
  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      low_side_delay_flag_out  <= 1'b0;
      high_side_delay_flag_out <= 1'b0;
      cpu_hold_out             <= 1'b0;
      in_deep_sleep_out        <= 1'b0;
      config_affected_out      <= 1'b0;
      low_sup_state_out        <= `ST_OFF;
      low_mon_state_out        <= `ST_OFF;
      high_sup_state_out       <= `ST_OFF;
      high_mon_state_out       <= `ST_OFF;
    end else begin
      low_side_delay_flag_out  <= low_busy;
      high_side_delay_flag_out <= high_busy;
      cpu_hold_out             <= state != S_ACTIVE;
      in_deep_sleep_out        <= state == S_SLEEP || state == S_STUCK;
      config_affected_out      <= affected;
      low_sup_state_out  <= sup_state(low_ctl, state[0]);
      high_sup_state_out <= sup_state(high_ctl, state[0]);
      low_mon_state_out  <= mon_state(low_ctl, state[0]);
      high_mon_state_out <= mon_state(high_ctl, state[0]);
    end
  end
endmodule

/* File: rtl/supply_supervisor_regs.vh */
// timing constants and control-field positions for the supply supervisor
// assumes a 250 MHz core clock (4 ns period)
`ifndef SUPPLY_SUPERVISOR_REGS_VH
`define SUPPLY_SUPERVISOR_REGS_VH

`define CLK_PERIOD_PS        32'd4000
// settling / masking times in ns, as printed
`define SLOW_SETTLE_NS       32'd150000
`define FAST_SETTLE_NS       32'd2000
`define SUBCLK_FAST_NS       32'd6000
// derived cycle counts (longest times round down, least round up)
`define SLOW_SETTLE_CYC      ((`SLOW_SETTLE_NS * 32'd1000) / `CLK_PERIOD_PS)
`define FAST_SETTLE_CYC      ((`FAST_SETTLE_NS * 32'd1000 + `CLK_PERIOD_PS - 32'd1) / `CLK_PERIOD_PS)
`define SUBCLK_FAST_CYC      ((`SUBCLK_FAST_NS * 32'd1000) / `CLK_PERIOD_PS)

// per-side control word bit positions
`define CTL_SUP_EN           0
`define CTL_SUP_FP           1
`define CTL_SUP_KEEP         2
`define CTL_MON_EN           3
`define CTL_MON_FP           4
`define CTL_AUTO             5
`define CTL_WIDTH            6
`define CTL_RESET            6'h01

// unit state codes
`define ST_OFF               2'h0
`define ST_NORMAL            2'h1
`define ST_FULL              2'h2

`endif

/* File: rtl/settle_timer.v */
// loadable down-counter used for the per-side settling delays
// load pulse comes from logic on the same clock
module settle_timer #(
  parameter W = 16
) (
  input  wire         clk_in,
  input  wire         resetn_in,
  input  wire         load_in,
  input  wire [W-1:0] count_in,
  output reg          busy_out
);
  reg [W-1:0] remain;

  // reload wins over countdown; busy clears on reaching zero
  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      remain   <= {W{1'b0}};
      busy_out <= 1'b0;
    end else if (load_in) begin
      remain   <= count_in;
      busy_out <= 1'b1;
    end else if (remain > {{(W-1){1'b0}}, 1'b1}) begin
      remain <= remain - {{(W-1){1'b0}}, 1'b1};
    end else begin
      remain   <= {W{1'b0}};
      busy_out <= 1'b0;
    end
  end
endmodule

/* File: testbench/supervisor_props.sv */
// port assertions for the supply supervisor and wake-up block
// bound to that block; needs the control word layout header
`include "supply_supervisor_regs.vh"
module supervisor_props #(
  parameter [31:0] SLOW_CYC   = 32'd40,
  parameter [31:0] SUBCLK_CYC = 32'd12
) (
  input wire                  clk_in,
  input wire                  resetn_in,
  input wire [`CTL_WIDTH-1:0] low_side_supervisor_ctrl_in,
  input wire                  low_ctrl_write_in,
  input wire                  high_ctrl_write_in,
  input wire                  core_level_raise_in,
  input wire                  subsystem_clock_on_osc_in,
  input wire [1:0]            sleep_mode_req_in,
  input wire                  sleep_enter_in,
  input wire                  soft_power_up_clear_in,
  input wire                  low_side_delay_flag_out,
  input wire                  high_side_delay_flag_out,
  input wire                  cpu_hold_out,
  input wire                  in_deep_sleep_out,
  input wire                  subsystem_clock_fast_out,
  input wire                  core_level_reset_out,
  input wire                  wake_lost_out
);
  int lcnt;
  int scnt;

  default clocking @(posedge clk_in); endclocking
  default disable iff (!resetn_in);

  // run lengths of the low delay flag and the fast subsystem clock
  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      lcnt <= 0;
      scnt <= 0;
    end else begin
      lcnt <= low_side_delay_flag_out ? lcnt + 1 : 0;
      scnt <= subsystem_clock_fast_out ? scnt + 1 : 0;
    end
  end

  low_flag_rise_a: assert property (
    low_ctrl_write_in |-> ##[1:3] low_side_delay_flag_out)
    else $error("low delay flag missing after write");
  high_flag_rise_a: assert property (
    high_ctrl_write_in |-> ##[1:3] high_side_delay_flag_out)
    else $error("high delay flag missing after write");
  flag_bound_a: assert property (lcnt <= SLOW_CYC + 4)
    else $error("low delay flag stays too long");
  sleep_entry_a: assert property (
    sleep_enter_in && sleep_mode_req_in[1] && !cpu_hold_out
    |-> ##[1:2] in_deep_sleep_out && cpu_hold_out)
    else $error("sleep entry not taken");
  mode_ignore_a: assert property (
    sleep_enter_in && !sleep_mode_req_in[1] && !cpu_hold_out
    |=> !in_deep_sleep_out) else $error("low mode code entered sleep");
  sleep_hold_a: assert property (in_deep_sleep_out |-> cpu_hold_out)
    else $error("processor runs while asleep");
  subclk_src_a: assert property (
    $rose(subsystem_clock_fast_out) |-> subsystem_clock_on_osc_in)
    else $error("fast subsystem clock without oscillator source");
  subclk_len_a: assert property (scnt <= SUBCLK_CYC + 1)
    else $error("fast subsystem clock lasts too long");
  core_reset_a: assert property (
    core_level_raise_in && low_side_supervisor_ctrl_in[0]
    && low_side_supervisor_ctrl_in[1] |-> ##[1:3] core_level_reset_out)
    else $error("no reset after raise in full performance");
  lost_clear_a: assert property (
    soft_power_up_clear_in |-> ##[1:2] !wake_lost_out)
    else $error("soft clear left lost wake");

  cover property (wake_lost_out);
  cover property (core_level_reset_out);
  cover property ($fell(cpu_hold_out));
endmodule

bind supply_supervisor_wakeup_ctrl supervisor_props #(
  .SLOW_CYC(SLOW_CYC), .SUBCLK_CYC(SUBCLK_CYC)) u_props (
  .clk_in(clk_in), .resetn_in(resetn_in),
  .low_side_supervisor_ctrl_in(low_side_supervisor_ctrl_in),
  .low_ctrl_write_in(low_ctrl_write_in),
  .high_ctrl_write_in(high_ctrl_write_in),
  .core_level_raise_in(core_level_raise_in),
  .subsystem_clock_on_osc_in(subsystem_clock_on_osc_in),
  .sleep_mode_req_in(sleep_mode_req_in), .sleep_enter_in(sleep_enter_in),
  .soft_power_up_clear_in(soft_power_up_clear_in),
  .low_side_delay_flag_out(low_side_delay_flag_out),
  .high_side_delay_flag_out(high_side_delay_flag_out),
  .cpu_hold_out(cpu_hold_out), .in_deep_sleep_out(in_deep_sleep_out),
  .subsystem_clock_fast_out(subsystem_clock_fast_out),
  .core_level_reset_out(core_level_reset_out),
  .wake_lost_out(wake_lost_out));

/* File: testbench/tb.sv */
// self-checking bench for the supply supervisor and wake-up block
// drives every input itself; short counts stand in for long settles
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SL = 40, FA = 5, SC = 12, LO = 10;
  logic       clk = 0, resetn = 0, lwr = 0, hwr = 0, raise = 0;
  logic       mfast = 0, osc = 0, ent = 0, irq = 0, spc = 0;
  logic [5:0] lw = 6'h01, hw = 6'h01;
  logic [1:0] mode = 2'h3;
  wire        lf, hf, hold, slp, sfast, cres, aff, lost;
  wire  [1:0] ls, lm, hs, hm;
  int         mismatches = 0, checks_done = 0, lfsr = 75;

  supply_supervisor_wakeup_ctrl #(.SLOW_CYC(SL), .FAST_CYC(FA),
    .SUBCLK_CYC(SC), .LOSS_CYC(LO)) DUT (
    .clk_in(clk), .resetn_in(resetn), .low_side_supervisor_ctrl_in(lw),
    .low_ctrl_write_in(lwr), .high_side_supervisor_ctrl_in(hw),
    .high_ctrl_write_in(hwr), .core_level_raise_in(raise),
    .main_clock_fast_in(mfast), .subsystem_clock_on_osc_in(osc),
    .sleep_mode_req_in(mode), .sleep_enter_in(ent), .wake_irq_in(irq),
    .soft_power_up_clear_in(spc), .low_side_delay_flag_out(lf),
    .high_side_delay_flag_out(hf), .cpu_hold_out(hold),
    .in_deep_sleep_out(slp), .subsystem_clock_fast_out(sfast),
    .core_level_reset_out(cres), .config_affected_out(aff),
    .wake_lost_out(lost), .low_sup_state_out(ls), .low_mon_state_out(lm),
    .high_sup_state_out(hs), .high_mon_state_out(hm));

  // core clock, 4 ns period
  initial forever #2 clk = ~clk;

  task automatic close_out;
    if (mismatches == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // wait edges, then step just past the last one
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask

  function automatic int nxt(input int v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction

  function automatic logic [1:0] act(input logic en, fp);
    return en ? (fp ? 2'h2 : 2'h1) : 2'h0;
  endfunction

  // supervisor and monitor state, awake or asleep
  function automatic logic [3:0] st(input logic [5:0] c, input logic s);
    logic [1:0] a, b;
    a = act(c[0], c[1]);
    b = act(c[3], c[4]);
    if (s && c[5]) begin
      a = (c[0] && c[2] && c[1]) ? 2'h1 : 2'h0;
      b = (c[3] && c[4]) ? 2'h1 : 2'h0;
    end else if (s && !c[2]) begin
      a = 2'h0;
    end
    return {a, b};
  endfunction

  // fast-waking low side with a high side that turns off in sleep
  function automatic logic affm(input logic [5:0] l, h);
    logic fl;
    fl = !l[0] || l[1] || !l[3] || l[4];
    return fl && ((h[0] && !h[1] && (!h[2] || h[5]))
                  || (h[3] && !h[4] && h[5]));
  endfunction

  // write both words, then wait until both settle flags clear
  task automatic wr(input logic [5:0] l, h);
    int n;
    lw = l;
    hw = h;
    lwr = 1;
    hwr = 1;
    tick(1);
    lwr = 0;
    hwr = 0;
    tick(2);
    chk({lf, hf}, 2'h3);
    for (n = 0; n < 300 && (lf === 1'b1 || hf === 1'b1); n++) tick(1);
    chk({lf, hf}, 2'h0);
  endtask

  // configure, raise the core level, sleep, wake and judge the wake
  task automatic trial(input logic [5:0] l, h, input logic mf, oc,
                       input logic [1:0] m, input int gap);
    int held, sf, t, ex;
    logic bad, cr, okf;
    wr(l, h);
    chk(aff, affm(l, h));
    chk({ls, lm, hs, hm}, {st(l, 0), st(h, 0)});
    raise = 1;
    cr = 0;
    repeat (3) begin
      tick(1);
      raise = 0;
      cr = cr | cres;
    end
    chk(cr, l[0] & l[1]);
    mfast = mf;
    osc = oc;
    mode = m;
    ent = 1;
    tick(1);
    ent = 0;
    tick(gap);
    chk({slp, ls, lm, hs, hm}, {1'b1, st(l, 1), st(h, 1)});
    irq = 1;
    held = 0;
    sf = 0;
    for (t = 0; t < 200 && (hold === 1'b1 || sfast === 1'b1); t++) begin
      held += hold === 1'b1;
      sf += sfast === 1'b1;
      tick(1);
    end
    irq = 0;
    bad = affm(l, h) && gap < LO;
    chk(lost, bad);
    if (bad) begin
      spc = 1;
      tick(1);
      spc = 0;
      tick(3);
      chk({lost, hold}, 2'h0);
    end else begin
      ex = ((!l[0] || l[1]) && (!l[3] || l[4])) ? FA : SL;
      chk(held >= ex + 2 && held <= ex + 7, 1'h1);
    end
    okf = oc && m == 2'h3 && !bad ? sf >= SC - 1 && sf <= SC + 1 : sf == 0;
    chk(okf, 1'h1);
  endtask

  // main sequence: reset, refused entry, fixed cases, random cases
  initial begin
    logic [7:0] r;
    int k, g;
    tick(6);
    resetn = 1;
    tick(1);
    chk({ls, lm, hs, hm}, {st(6'h01, 0), st(6'h01, 0)});
    mode = 2'h1;
    ent = 1;
    tick(1);
    ent = 0;
    tick(2);
    chk({slp, hold}, 2'h0);
    trial(6'h01, 6'h01, 1'b0, 1'b1, 2'h3, LO + 3);
    trial(6'h1b, 6'h3f, 1'b1, 1'b1, 2'h3, LO + 3);
    trial(6'h1b, 6'h21, 1'b1, 1'b0, 2'h2, 3);
    trial(6'h09, 6'h09, 1'b0, 1'b0, 2'h2, 3);
    for (k = 0; k < 10; k++) begin
      lfsr = nxt(lfsr);
      r = lfsr[7:0];
      lfsr = nxt(lfsr);
      g = r[7] ? 3 : LO + 3;
      trial(r[5:0], lfsr[5:0], lfsr[6], r[6], {1'b1, lfsr[7]}, g);
    end
    // entry straight after a write skips settling: early wake is lost
    lwr = 1;
    tick(1);
    lwr = 0;
    ent = 1;
    tick(1);
    ent = 0;
    irq = 1;
    tick(6);
    chk({lost, hold, sfast}, 3'h6);
    irq = 0;
    spc = 1;
    tick(1);
    spc = 0;
    tick(3);
    chk({lost, hold}, 2'h0);
    close_out();
  end

  // cut a hang short; the run needs well under this
  initial begin
    #100us;
    mismatches++;
    close_out();
  end
endmodule
